// ===== verilog/eprom_prog_consts.vh
// Timing counts, limits and pin codes for the byte programming sequencer.
// Operation
// - Each byte gets initial program pulses, then one final overprogram pulse.
// - Address is driven to the target byte and held for the whole byte sequence.
// - Core supply is raised to programming level before the first pulse.
// - First pulse lasts 1 ms, followed by a verify read and compare.
// - A byte passing after one pulse gets a 3 ms overprogram pulse.
// - On verify failure, further 1 ms pulses follow, up to 25, counted.
// - Overprogram pulse is three times the pulse count, at most 75 ms.
// - A byte still failing after 25 pulses stops the run as failed.
// - After each byte, advance to the next address until all are done.
// - Lower supply to normal, read back every byte, compare for pass or fail.
// - Initial pulse width stays within 0.95 ms to 1.05 ms.
// - Overprogram width stays within 2.85 ms to 78.75 ms, scaled by count.
// - Verify waits at least the 70 ns output-enable-to-valid delay before sampling.
// - Data lines are not driven until 130 ns after output enable rises.
// - Identification mode: all address lines low except bit 0 (low for maker, high for type) and the raised identification line.
// - Program: chip low, output high, strobe low; verify: chip low, output low, strobe high.
`ifndef EPROM_PROG_CONSTS_VH
`define EPROM_PROG_CONSTS_VH
`define CLK_PERIOD_PS       4000
`define PULSE_TIME_US       1000
`define PULSE_CYCLES        ((`PULSE_TIME_US * 1000000) / `CLK_PERIOD_PS)
`define MS_TIME_US          1000
`define MS_CYCLES           ((`MS_TIME_US * 1000000) / `CLK_PERIOD_PS)
`define OE_VALID_NS         70
`define OE_VALID_CYCLES     ((`OE_VALID_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define RELEASE_NS          130
`define RELEASE_CYCLES      ((`RELEASE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define SETUP_US            2
`define SETUP_CYCLES        ((`SETUP_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define MAX_PULSES          25
`define OVERPROG_FACTOR     3
`define ID_SEL_BIT          0
`define ID_LINE_BIT         9
`endif

// ===== verilog/source_image_ram.v
// Byte memory holding the source image to be programmed.
`timescale 1ns/1ps
`default_nettype none
module source_image_ram #(
    parameter AW = 13
) (
    input  wire          ref_clk_i,
    input  wire          wr_en_i,
    input  wire [AW-1:0] wr_addr_i,
    input  wire [7:0]    wr_data_i,
    input  wire [AW-1:0] rd_addr_i,
    output reg  [7:0]    rd_data_o
);
    reg [7:0] mem [0:(1<<AW)-1];
    // Writes store a byte; reads come out of a register one cycle later.
    always @(posedge ref_clk_i)
    begin
        if (wr_en_i)
        begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end
endmodule
`default_nettype wire

// ===== verilog/eprom_byte_program_sequencer.v
// Host sequencer that programs, verifies and reads back a UV EPROM over its pins.
`timescale 1ns/1ps
`default_nettype none
`include "eprom_prog_consts.vh"
module eprom_byte_program_sequencer #(
    parameter AW           = 13,
    parameter PULSE_CYCLES = `PULSE_CYCLES,
    parameter MS_CYCLES    = `MS_CYCLES,
    parameter SETUP_CYCLES = `SETUP_CYCLES
) (
    input  wire          ref_clk_i,
    input  wire          rst_b_i,
    input  wire          load_en_i,
    input  wire [AW-1:0] load_addr_i,
    input  wire [7:0]    load_data_i,
    input  wire          start_i,
    input  wire [AW-1:0] last_addr_i,
    input  wire          id_read_i,
    input  wire [7:0]    data_in_i,
    output reg  [AW-1:0] byte_address_o,
    output reg  [7:0]    data_out_o,
    output reg           data_oe_n_o,
    output reg           chip_en_n_o,
    output reg           out_en_n_o,
    output reg           program_strobe_n_o,
    output reg           vpp_on_o,
    output reg           vcc_high_o,
    output reg           id_mode_line_o,
    output reg           busy_o,
    output reg           byte_fail_o,
    output reg  [AW-1:0] fail_addr_o,
    output reg           done_o,
    output reg           pass_o,
    output reg  [7:0]    id_maker_o,
    output reg  [7:0]    id_type_o
);
    localparam [3:0] S_IDLE   = 4'h0;
    localparam [3:0] S_POWER  = 4'h1;
    localparam [3:0] S_SETUP  = 4'h2;
    localparam [3:0] S_PULSE  = 4'h3;
    localparam [3:0] S_REL    = 4'h4;
    localparam [3:0] S_VERIFY = 4'h5;
    localparam [3:0] S_OVER   = 4'h6;
    localparam [3:0] S_NEXT   = 4'h7;
    localparam [3:0] S_LOWER  = 4'h8;
    localparam [3:0] S_READ   = 4'h9;
    localparam [3:0] S_FINISH = 4'hA;
    localparam [3:0] S_ID     = 4'hB;
    localparam [31:0] OE_WAIT  = `OE_VALID_CYCLES + 2;
    localparam [31:0] REL_WAIT = `RELEASE_CYCLES;

    reg [3:0]    state;
    reg [31:0]   timer;
    reg [31:0]   ms_left;
    reg [4:0]    pulses;
    reg          id_phase;
    reg          readback;
    reg [7:0]    din_meta;
    reg [7:0]    din_sync;
    wire [7:0]   src_byte;

    source_image_ram #(.AW(AW)) u_ram (
        .ref_clk_i (ref_clk_i),
        .wr_en_i   (load_en_i & ~busy_o),
        .wr_addr_i (load_addr_i),
        .wr_data_i (load_data_i),
        .rd_addr_i (byte_address_o),
        .rd_data_o (src_byte)
    );

    // Device data returns through two flip-flops before it is compared.
    always @(posedge ref_clk_i)
    begin
        din_meta <= data_in_i;
        din_sync <= din_meta;
    end

    always @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
        begin
            state              <= S_IDLE;
            timer              <= 32'h0000_0000;
            ms_left            <= 32'h0000_0000;
            pulses             <= 5'h00;
            id_phase           <= 1'b0;
            readback           <= 1'b0;
            byte_address_o     <= {AW{1'b0}};
            data_out_o         <= 8'h00;
            data_oe_n_o        <= 1'b1;
            chip_en_n_o        <= 1'b1;
            out_en_n_o         <= 1'b1;
            program_strobe_n_o <= 1'b1;
            vpp_on_o           <= 1'b0;
            vcc_high_o         <= 1'b0;
            id_mode_line_o     <= 1'b0;
            busy_o             <= 1'b0;
            byte_fail_o        <= 1'b0;
            fail_addr_o        <= {AW{1'b0}};
            done_o             <= 1'b0;
            pass_o             <= 1'b0;
            id_maker_o         <= 8'h00;
            id_type_o          <= 8'h00;
        end
        else
        begin
            done_o      <= 1'b0;
            byte_fail_o <= 1'b0;
            if (timer != 32'h0000_0000)
            begin
                timer <= timer - 32'h0000_0001;
            end
            case (state)
                S_IDLE:
                begin
                    if (start_i)
                    begin
                        busy_o         <= 1'b1;
                        byte_address_o <= {AW{1'b0}};
                        vcc_high_o     <= 1'b1;
                        vpp_on_o       <= 1'b1;
                        chip_en_n_o    <= 1'b0;
                        timer          <= SETUP_CYCLES + REL_WAIT;
                        state          <= S_POWER;
                    end
                    else if (id_read_i)
                    begin
                        busy_o         <= 1'b1;
                        byte_address_o <= {AW{1'b0}};
                        id_mode_line_o <= 1'b1;
                        id_phase       <= 1'b0;
                        chip_en_n_o    <= 1'b0;
                        timer          <= SETUP_CYCLES;
                        state          <= S_ID;
                    end
                end
                S_ID:
                begin
                    if (timer == 32'h0000_0000)
                    begin
                        if (out_en_n_o)
                        begin
                            out_en_n_o <= 1'b0;
                            timer      <= OE_WAIT;
                        end
                        else if (!id_phase)
                        begin
                            id_maker_o                  <= din_sync;
                            id_phase                    <= 1'b1;
                            byte_address_o[`ID_SEL_BIT] <= 1'b1;
                            timer                       <= SETUP_CYCLES;
                        end
                        else
                        begin
                            id_type_o      <= din_sync;
                            out_en_n_o     <= 1'b1;
                            chip_en_n_o    <= 1'b1;
                            id_mode_line_o <= 1'b0;
                            byte_address_o <= {AW{1'b0}};
                            busy_o         <= 1'b0;
                            done_o         <= 1'b1;
                            pass_o         <= 1'b1;
                            state          <= S_IDLE;
                        end
                    end
                end
                S_POWER:
                begin
                    if (timer == 32'h0000_0000)
                    begin
                        pulses <= 5'h00;
                        state  <= S_SETUP;
                        timer  <= SETUP_CYCLES;
                    end
                end
                S_SETUP:
                begin
                    // Address held from here to the end of the byte.
                    data_out_o  <= src_byte;
                    data_oe_n_o <= 1'b0;
                    if (timer == 32'h0000_0000)
                    begin
                        program_strobe_n_o <= 1'b0;
                        pulses             <= pulses + 5'h01;
                        timer              <= PULSE_CYCLES - 1;
                        state              <= S_PULSE;
                    end
                end
                S_PULSE:
                begin
                    if (timer == 32'h0000_0000)
                    begin
                        program_strobe_n_o <= 1'b1;
                        data_oe_n_o        <= 1'b1;
                        out_en_n_o         <= 1'b0;
                        timer              <= OE_WAIT;
                        state              <= S_VERIFY;
                    end
                end
                S_VERIFY:
                begin
                    if (timer == 32'h0000_0000)
                    begin
                        out_en_n_o <= 1'b1;
                        timer      <= REL_WAIT;
                        state      <= S_REL;
                        readback   <= (din_sync == src_byte);
                    end
                end
                S_REL:
                begin
                    if (timer == 32'h0000_0000)
                    begin
                        if (readback)
                        begin
                            data_oe_n_o        <= 1'b0;
                            program_strobe_n_o <= 1'b0;
                            ms_left            <= `OVERPROG_FACTOR * pulses;
                            timer              <= MS_CYCLES - 1;
                            state              <= S_OVER;
                        end
                        else if (pulses == `MAX_PULSES)
                        begin
                            byte_fail_o <= 1'b1;
                            fail_addr_o <= byte_address_o;
                            pass_o      <= 1'b0;
                            state       <= S_FINISH;
                        end
                        else
                        begin
                            timer <= SETUP_CYCLES;
                            state <= S_SETUP;
                        end
                    end
                end
                S_OVER:
                begin
                    if (timer == 32'h0000_0000)
                    begin
                        if (ms_left <= 32'h0000_0001)
                        begin
                            program_strobe_n_o <= 1'b1;
                            timer              <= SETUP_CYCLES;
                            state              <= S_NEXT;
                        end
                        else
                        begin
                            ms_left <= ms_left - 32'h0000_0001;
                            timer   <= MS_CYCLES - 1;
                        end
                    end
                end
                S_NEXT:
                begin
                    if (timer == 32'h0000_0000)
                    begin
                        data_oe_n_o <= 1'b1;
                        pulses      <= 5'h00;
                        timer       <= SETUP_CYCLES;
                        if (byte_address_o == last_addr_i)
                        begin
                            vpp_on_o       <= 1'b0;
                            vcc_high_o     <= 1'b0;
                            byte_address_o <= {AW{1'b0}};
                            pass_o         <= 1'b1;
                            state          <= S_LOWER;
                        end
                        else
                        begin
                            byte_address_o <= byte_address_o + {{(AW-1){1'b0}}, 1'b1};
                            state          <= S_SETUP;
                        end
                    end
                end
                S_LOWER:
                begin
                    if (timer == 32'h0000_0000)
                    begin
                        out_en_n_o <= 1'b0;
                        timer      <= OE_WAIT;
                        state      <= S_READ;
                    end
                end
                S_READ:
                begin
                    if (timer == 32'h0000_0000)
                    begin
                        if (din_sync != src_byte)
                        begin
                            pass_o      <= 1'b0;
                            byte_fail_o <= 1'b1;
                            fail_addr_o <= byte_address_o;
                        end
                        if (byte_address_o == last_addr_i)
                        begin
                            state <= S_FINISH;
                        end
                        else
                        begin
                            byte_address_o <= byte_address_o + {{(AW-1){1'b0}}, 1'b1};
                            timer          <= OE_WAIT;
                        end
                    end
                end
                S_FINISH:
                begin
                    program_strobe_n_o <= 1'b1;
                    out_en_n_o         <= 1'b1;
                    chip_en_n_o        <= 1'b1;
                    data_oe_n_o        <= 1'b1;
                    vpp_on_o           <= 1'b0;
                    vcc_high_o         <= 1'b0;
                    busy_o             <= 1'b0;
                    done_o             <= 1'b1;
                    state              <= S_IDLE;
                end
                default:
                begin
                    state <= S_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== tb/prog_seq_monitor.sv
// Pin sequencing assertions for the byte programming sequencer.
`timescale 1ns/1ps
`default_nettype none
module prog_seq_monitor #(
    parameter AW           = 13,
    parameter PULSE_CYCLES = 20,
    parameter MS_CYCLES    = 20
) (
    input wire logic          ref_clk_i,
    input wire logic          rst_b_i,
    input wire logic          start_i,
    input wire logic          id_read_i,
    input wire logic [AW-1:0] byte_address_o,
    input wire logic          data_oe_n_o,
    input wire logic          chip_en_n_o,
    input wire logic          out_en_n_o,
    input wire logic          program_strobe_n_o,
    input wire logic          vpp_on_o,
    input wire logic          vcc_high_o,
    input wire logic          id_mode_line_o,
    input wire logic          busy_o,
    input wire logic          done_o
);
    logic [31:0] low_len;
    logic [31:0] oe_hi;
    // Strobe low length and cycles since output enable went inactive.
    always @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
        begin
            low_len <= 32'h0000_0000;
            oe_hi   <= 32'h0000_0040;
        end
        else
        begin
            low_len <= program_strobe_n_o ? 32'h0000_0000 : low_len + 1;
            oe_hi   <= !out_en_n_o ? 32'h0000_0000 : (oe_hi < 64 ? oe_hi + 1 : oe_hi);
        end
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    chk_pulse_width: assert property ($rose(program_strobe_n_o) |->
        low_len == PULSE_CYCLES || (low_len % (3 * MS_CYCLES) == 0
        && low_len != 0 && low_len <= 75 * MS_CYCLES)) else $error("bad strobe width");
    chk_prog_levels: assert property (!program_strobe_n_o |->
        !chip_en_n_o && out_en_n_o && !data_oe_n_o && vpp_on_o && vcc_high_o)
        else $error("bad program levels");
    chk_verify_float: assert property (!out_en_n_o |-> data_oe_n_o)
        else $error("host drives during read");
    chk_release_gap: assert property ($fell(data_oe_n_o) |-> oe_hi >= 33)
        else $error("data driven too soon");
    chk_addr_hold: assert property (!program_strobe_n_o && !$past(program_strobe_n_o)
        |-> $stable(byte_address_o)) else $error("address moved in pulse");
    chk_done_single: assert property (done_o |=> !done_o)
        else $error("done too long");
    chk_done_idle: assert property (done_o |-> ##[0:2] !busy_o)
        else $error("busy after done");
    chk_start_busy: assert property (!busy_o && (start_i || id_read_i) |=> busy_o)
        else $error("request not taken");
    chk_readback_vcc: assert property (!out_en_n_o && !vpp_on_o |-> !vcc_high_o)
        else $error("readback at high supply");
    chk_id_lines: assert property (id_mode_line_o |->
        byte_address_o[AW-1:1] == 0 && !vpp_on_o) else $error("bad id address");
    cover property ($rose(program_strobe_n_o) && low_len > PULSE_CYCLES);
    cover property (id_mode_line_o && byte_address_o[0]);
    cover property (done_o);
endmodule
bind eprom_byte_program_sequencer prog_seq_monitor #(
    .AW(AW), .PULSE_CYCLES(PULSE_CYCLES), .MS_CYCLES(MS_CYCLES)
) mon (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .start_i(start_i), .id_read_i(id_read_i),
    .byte_address_o(byte_address_o), .data_oe_n_o(data_oe_n_o),
    .chip_en_n_o(chip_en_n_o), .out_en_n_o(out_en_n_o),
    .program_strobe_n_o(program_strobe_n_o), .vpp_on_o(vpp_on_o),
    .vcc_high_o(vcc_high_o), .id_mode_line_o(id_mode_line_o),
    .busy_o(busy_o), .done_o(done_o)
);
`default_nettype wire

// ===== tb/eprom_cell_model.sv
// Behavioural model of the programmable memory device on the pins.
`timescale 1ns/1ps
`default_nettype none
module eprom_cell_model #(
    parameter       PULSE_CYCLES = 20,
    parameter [7:0] MAKER_ID     = 8'h5a, // Arbitrary value.
    parameter [7:0] TYPE_ID      = 8'hc3  // Arbitrary value.
) (
    input wire logic        ref_clk_i,
    input wire logic [12:0] addr_i,
    input wire logic [7:0]  dq_i,
    input wire logic        dq_oe_n_i,
    input wire logic        ce_n_i,
    input wire logic        oe_n_i,
    input wire logic        program_strobe_n_i,
    input wire logic        vpp_i,
    input wire logic        id_line_i,
    output logic [7:0]      dq_o
);
    logic [7:0] mem [0:15];
    int         need [0:15];
    int         cnt [0:15];
    int         op_len [0:15];
    int         low_len = 0;
    int         bad_addr = -1;
    logic [7:0] last = 8'h00;
    logic [7:0] pdata = 8'h00;
    logic [7:0] rd;
    wire  [3:0] a = addr_i[3:0];
    wire        drive = !ce_n_i && !oe_n_i && program_strobe_n_i;
    always @(posedge ref_clk_i)
    begin
        if (id_line_i)
            rd <= addr_i[0] ? TYPE_ID : MAKER_ID;
        else if (cnt[a] < need[a])
            rd <= 8'hff;
        else
            rd <= mem[a] ^ ((!vpp_i && addr_i == bad_addr) ? 8'h01 : 8'h00);
    end
    // Released lines show the inverse of the last value.
    assign dq_o = drive ? rd : ~last;
    always @(posedge ref_clk_i)
    begin
        if (drive)
            last <= rd;
        low_len <= program_strobe_n_i ? 0 : low_len + 1;
        if (!program_strobe_n_i && !ce_n_i && oe_n_i && !dq_oe_n_i && vpp_i)
            pdata <= dq_i;
        if (program_strobe_n_i && low_len != 0)
        begin
            if (low_len == PULSE_CYCLES)
                cnt[a] <= cnt[a] + 1;
            else
                op_len[a] <= low_len;
            mem[a] <= pdata;
        end
    end
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the byte programming sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam AW = 13;
    localparam MS = 20;
    logic          clk = 0, rst_b = 0, load_en = 0, start = 0, id_read = 0;
    logic [AW-1:0] load_addr = 0, last_addr = 3;
    logic [7:0]    load_data = 0;
    wire  [AW-1:0] addr, fail_addr;
    wire  [7:0]    dout, din, maker, dtype;
    wire           doe_n, ce_n, oe_n, pgm_n, vpp, vcch, idl, busy, bfail, done, pass;
    int            fail_count = 0, cmp_count = 0, nf;
    logic [AW-1:0] fa;
    logic          ps;
    always #2 clk = ~clk;
    eprom_byte_program_sequencer #(.AW(AW), .PULSE_CYCLES(20), .MS_CYCLES(MS),
        .SETUP_CYCLES(4)) uut (
        .ref_clk_i(clk), .rst_b_i(rst_b), .load_en_i(load_en), .load_addr_i(load_addr),
        .load_data_i(load_data), .start_i(start), .last_addr_i(last_addr),
        .id_read_i(id_read), .data_in_i(din), .byte_address_o(addr), .data_out_o(dout),
        .data_oe_n_o(doe_n), .chip_en_n_o(ce_n), .out_en_n_o(oe_n),
        .program_strobe_n_o(pgm_n), .vpp_on_o(vpp), .vcc_high_o(vcch),
        .id_mode_line_o(idl), .busy_o(busy), .byte_fail_o(bfail), .fail_addr_o(fail_addr),
        .done_o(done), .pass_o(pass), .id_maker_o(maker), .id_type_o(dtype));
    eprom_cell_model #(.PULSE_CYCLES(20)) dev (
        .ref_clk_i(clk), .addr_i(addr), .dq_i(dout), .dq_oe_n_i(doe_n), .ce_n_i(ce_n),
        .oe_n_i(oe_n), .program_strobe_n_i(pgm_n), .vpp_i(vpp), .id_line_i(idl),
        .dq_o(din));
    task check(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task complete_run;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Issues one request and waits for done, gathering byte failures.
    task run(input bit id);
        int k;
        nf = 0;
        for (k = 0; k < 16; k++)
            dev.cnt[k] = 0;
        @(posedge clk);
        if (id) id_read <= 1; else start <= 1;
        @(posedge clk);
        id_read <= 0;
        start <= 0;
        for (k = 0; k < 20000; k++)
        begin
            @(posedge clk);
            #1;
            if (bfail === 1'b1) begin nf++; fa = fail_addr; end
            if (done === 1'b1) break;
        end
        ps = pass;
        if (k == 20000) check(0, 1);
    endtask
    task t_reset;
        check({pgm_n, ce_n, oe_n, doe_n, vpp, vcch, busy, done}, 8'hf0);
    endtask
    task t_program;
        int i;
        int nd [4];
        nd[0] = 1;
        nd[1] = 3;
        nd[2] = 25;
        nd[3] = 2;
        for (i = 0; i < 4; i++)
        begin
            dev.need[i] = nd[i];
            @(posedge clk);
            load_en <= 1;
            load_addr <= i;
            load_data <= 8'h3c + 8'(i * 8'h11);
            @(posedge clk);
            load_en <= 0;
        end
        run(0);
        check({nf, ps}, {32'h0, 1'b1});
        for (i = 0; i < 4; i++)
        begin
            check(dev.cnt[i], nd[i]);
            check(dev.op_len[i], 3 * nd[i] * MS);
            check(dev.mem[i], 8'h3c + 8'(i * 8'h11));
        end
    endtask
    task t_fail;
        dev.need[1] = 26;
        run(0);
        check({nf, fa, ps}, {32'h1, 13'h0001, 1'b0});
        check(dev.cnt[1], 25);
        check(dev.cnt[2], 0);
        dev.need[1] = 1;
    endtask
    task t_readback;
        dev.need[2] = 1;
        dev.bad_addr = 2;
        run(0);
        check({nf, fa, ps}, {32'h1, 13'h0002, 1'b0});
        dev.bad_addr = -1;
    endtask
    task t_ident;
        run(1);
        check({maker, dtype, ps}, {8'h5a, 8'hc3, 1'b1});
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        rst_b <= 1;
        @(posedge clk);
        #1;
        t_reset();
        t_program();
        t_fail();
        t_readback();
        t_ident();
        complete_run();
    end
    initial
    begin
        #200000;
        fail_count++;
        complete_run();
    end
endmodule
`default_nettype wire
